/* File: hdl/cae_pkg.sv */
// constants, field layout and types of the channel alarm evaluator
`default_nettype none
package cae_pkg;
  localparam int NSLOT = 6;
  // per-slot register block: slot s sits at s*SLOT_STRIDE
  localparam logic [7:0] SLOT_STRIDE  = 8'h20;
  localparam logic [2:0] IDX_CFG      = 3'h0;
  localparam logic [2:0] IDX_LEVEL    = 3'h1;
  localparam logic [2:0] IDX_DEV      = 3'h2;
  localparam logic [2:0] IDX_HYST     = 3'h3;
  localparam logic [2:0] IDX_DAMP     = 3'h4;
  localparam logic [2:0] IDX_REFLASH  = 3'h5;
  localparam logic [2:0] IDX_WINDOW   = 3'h6;
  localparam logic [2:0] IDX_DIGMASK  = 3'h7;
  // channel-wide registers
  localparam logic [7:0] OFF_SPAN     = 8'hc0;
  localparam logic [7:0] OFF_TPS      = 8'hc4;
  localparam logic [7:0] OFF_STATUS   = 8'hc8;
  // config word fields
  localparam int F_EN     = 0;   // 2 bits
  localparam int F_TYPE   = 2;   // 3 bits
  localparam int F_LATCH  = 5;
  localparam int F_CHGLOG = 6;
  localparam int F_MARK   = 7;
  localparam int F_HYST   = 8;
  localparam int F_DAMP   = 9;
  localparam int F_RFL    = 10;
  localparam int F_COMMON = 11;
  localparam int F_REFSEL = 12;  // 4 bits
  localparam int F_RELAY  = 16;  // 8 bits
  // status word fields
  localparam int S_ACTIVE = 0;
  localparam int S_FLASH  = 8;
  localparam int S_COND   = 16;
  // reset values
  localparam logic [31:0] RST_CFG  = 32'h0000_0000;
  localparam logic [15:0] RST_SPAN = 16'h0064;
  localparam logic [16:0] RST_TIME = 17'h0_0001;
  // damping range in seconds
  localparam logic [16:0] DAMP_MIN_S = 17'd1;
  localparam logic [16:0] DAMP_MAX_S = 17'd64800;
  localparam logic [7:0]  PCT_FULL   = 8'd100;
  typedef enum logic [1:0] {
    CAE_EN_OFF = 2'h0,
    CAE_EN_ALWAYS = 2'h1,
    CAE_EN_DIG = 2'h2
  } cae_en_t;
  typedef enum logic [2:0] {
    CAE_HIGH = 3'h0,
    CAE_LOW = 3'h1,
    CAE_DEV = 3'h2,
    CAE_RATE_UP = 3'h3,
    CAE_RATE_DN = 3'h4
  } cae_type_t;
  typedef enum logic [2:0] {
    CAE_S_IDLE = 3'b001,
    CAE_S_DAMP = 3'b010,
    CAE_S_ALARM = 3'b100
  } cae_state_t;
endpackage : cae_pkg
`default_nettype wire

/* File: hdl/cae_slot.sv */
// one alarm slot: condition, damping, hysteresis, latch, acknowledge, reflash
`default_nettype none
module cae_slot
  import cae_pkg::*;
#(
  parameter int VW   = 16,
  parameter int NDIG = 8
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 tick,
  input  wire logic                 sec,
  input  wire logic signed [VW-1:0] value,
  input  wire logic signed [VW-1:0] ref_value,
  input  wire logic [NDIG-1:0]      dig,
  input  wire logic                 ack,
  input  wire logic [31:0]          cfg,
  input  wire logic signed [VW-1:0] level,
  input  wire logic [VW-1:0]        dev,
  input  wire logic [7:0]           hyst_pct,
  input  wire logic [16:0]          damp_s,
  input  wire logic [16:0]          reflash_s,
  input  wire logic [16:0]          window_s,
  input  wire logic [NDIG-1:0]      dig_mask,
  input  wire logic [VW-1:0]        span,
  output logic                      active,
  output logic                      flash,
  output logic                      in_alarm
);
  localparam int XW = VW + 2;
  cae_state_t           state, next_state;
  logic                 unacked, next_unacked;
  logic [16:0]          damp_cnt, next_damp_cnt;
  logic [16:0]          rfl_cnt, next_rfl_cnt;
  logic [16:0]          win_cnt, next_win_cnt;
  logic signed [XW-1:0] snap, next_snap;
  logic signed [XW-1:0] vx, rx, lx, hx, tx, diff;
  logic                 enabled, raw, hold, entry, refl, latched;
  logic [16:0]          damp_lim;
  cae_type_t            atype;

  //////////////////////////////////////////////////////////////////////
  // condition evaluation
  always_comb begin
    atype = cae_type_t'(cfg[F_TYPE+:3]);
    latched = cfg[F_LATCH];
    vx = XW'(value);
    rx = XW'(ref_value);
    lx = XW'(level);
    hx = XW'((32'(span) * 32'(hyst_pct)) / 32'(PCT_FULL));
    tx = XW'((32'(span) * 32'(dev)) / 32'(PCT_FULL));
    diff = vx - rx;
    enabled = (cfg[F_EN+:2] == CAE_EN_ALWAYS)
           || ((cfg[F_EN+:2] == CAE_EN_DIG) && |(dig & dig_mask));
    raw = 1'b0;
    hold = 1'b0;
    case (atype)
      CAE_HIGH: begin
        raw = vx > lx;
        hold = cfg[F_HYST] ? (vx > lx - hx) : raw;
      end
      CAE_LOW: begin
        raw = vx < lx;
        hold = cfg[F_HYST] ? (vx < lx + hx) : raw;
      end
      CAE_DEV: begin
        raw = (diff > $signed(XW'(dev))) || (-diff > $signed(XW'(dev)));
        hold = raw;
      end
      CAE_RATE_UP: begin
        raw = (vx - snap) > tx;
        hold = raw;
      end
      CAE_RATE_DN: begin
        raw = (snap - vx) > tx;
        hold = raw;
      end
      default: begin
        raw = 1'b0;
        hold = 1'b0;
      end
    endcase
    damp_lim = (damp_s < DAMP_MIN_S) ? DAMP_MIN_S
             : (damp_s > DAMP_MAX_S) ? DAMP_MAX_S : damp_s;
  end

  //////////////////////////////////////////////////////////////////////
  // state, damping, acknowledge and reflash next values
  always_comb begin
    next_state = state;
    next_damp_cnt = damp_cnt;
    next_rfl_cnt = rfl_cnt;
    next_win_cnt = win_cnt;
    next_snap = snap;
    entry = 1'b0;
    refl = 1'b0;
    if (sec) begin
      if (win_cnt + 17'd1 >= window_s) begin
        next_win_cnt = '0;
        next_snap = vx;
      end else begin
        next_win_cnt = win_cnt + 17'd1;
      end
    end
    if (tick) begin
      case (state)
        CAE_S_IDLE: begin
          if (enabled && raw) begin
            if (cfg[F_DAMP]) begin
              next_state = CAE_S_DAMP;
              next_damp_cnt = '0;
            end else begin
              next_state = CAE_S_ALARM;
              entry = 1'b1;
            end
          end
        end
        CAE_S_DAMP: begin
          if (!enabled || !raw) begin
            next_state = CAE_S_IDLE;
          end else if (sec) begin
            next_damp_cnt = damp_cnt + 17'd1;
            if (damp_cnt + 17'd1 >= damp_lim) begin
              next_state = CAE_S_ALARM;
              entry = 1'b1;
            end
          end
        end
        CAE_S_ALARM: begin
          if (!enabled || !hold) begin
            next_state = CAE_S_IDLE;
          end
        end
        default: next_state = CAE_S_IDLE;
      endcase
    end
    // reflash after period if still in alarm
    if (ack) begin
      next_rfl_cnt = '0;
    end else if (cfg[F_RFL] && !unacked && state == CAE_S_ALARM && sec) begin
      if (rfl_cnt + 17'd1 >= reflash_s) begin
        refl = 1'b1;
        next_rfl_cnt = '0;
      end else begin
        next_rfl_cnt = rfl_cnt + 17'd1;
      end
    end
    // acknowledge clears pending flag; a new set wins
    if (entry || refl) begin
      next_unacked = 1'b1;
    end else if (ack || !enabled) begin
      next_unacked = 1'b0;
    end else begin
      next_unacked = unacked;
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CAE_S_IDLE;
      unacked <= 1'b0;
      damp_cnt <= '0;
      rfl_cnt <= '0;
      win_cnt <= '0;
      snap <= '0;
    end else begin
      state <= next_state;
      unacked <= next_unacked;
      damp_cnt <= next_damp_cnt;
      rfl_cnt <= next_rfl_cnt;
      win_cnt <= next_win_cnt;
      snap <= next_snap;
    end
  end

  // latched stays until cleared and acknowledged
  assign in_alarm = (state == CAE_S_ALARM);
  assign active = in_alarm || (latched && unacked);
  assign flash = latched ? unacked : (unacked && in_alarm);
endmodule : cae_slot
`default_nettype wire

/* File: hdl/cae_top.sv */
// channel alarm evaluator: APB registers, six slots, relay and logging outputs
//
// Overview of operation
// - up to six separate slots per channel
// - slot enable: off, always, digital
// - digital mode gated by selected inputs
// - high alarm when value above level
// - low alarm when value below level
// - deviation against tracked reference channel
// - rate up/down change within window
// - rate as percent, window in seconds
// - latched holds until clear and acknowledged
// - latched flashes until acknowledged, clear or not
// - active slot selects alarm logging rate
// - mark event on entry, chart flag after
// - active slot drives its relays, common relay
// - hysteresis span percent, not for deviation
// - damping delays entry into alarm only
// - damping time 1 to 64800 seconds
// - reflash after period if still alarmed
// - alarm log rate applied while channel alarmed
//
// Implementation choices: the register offsets and the APB register port.
`default_nettype none
module cae_top
  import cae_pkg::*;
#(
  parameter int VW            = 16,
  parameter int NDIG          = 8,
  parameter int NREF          = 8,
  parameter int NRELAY        = 8,
  parameter int TICKS_PER_SEC = 10
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sample_tick,
  input  wire logic signed [VW-1:0] chan_value,
  input  wire logic [NREF*VW-1:0]   ref_values,
  input  wire logic [NDIG-1:0]      dig_in,
  input  wire logic [NSLOT-1:0]     ack_req,
  output logic [NSLOT-1:0]          slot_active,
  output logic [NSLOT-1:0]          slot_flash,
  output logic [NRELAY-1:0]         relay_out,
  output logic                      common_relay,
  output logic                      log_rate_alarm,
  output logic                      chart_alarm,
  output logic                      mark_event
);
  // ticks per second after reset, from the parameter
  localparam logic [15:0] TPS_RST = 16'(TICKS_PER_SEC);

  // per-slot configuration words
  logic [31:0]     cfg [NSLOT];
  logic [VW-1:0]   lvl [NSLOT];
  logic [VW-1:0]   devr [NSLOT];
  logic [7:0]      hyst [NSLOT];
  logic [16:0]     damp [NSLOT];
  logic [16:0]     rfl [NSLOT];
  logic [16:0]     win [NSLOT];
  logic [NDIG-1:0] dmask [NSLOT];
  // channel-wide settings
  logic [VW-1:0]   span;
  logic [15:0]     tps;
  // bus decode and read path
  logic [31:0]     next_prdata;
  logic [31:0]     status;
  logic            hit;
  logic            setup;
  logic            wr_en;
  logic [2:0]      slot_sel;
  logic [2:0]      reg_idx;
  // synchronised digital enables
  logic [NDIG-1:0] dig_s1;
  logic [NDIG-1:0] dig_s2;
  // tick to second divider
  logic [15:0]     tick_cnt;
  logic [15:0]     next_tick_cnt;
  logic            sec;
  // per-slot results
  logic [NSLOT-1:0] act;
  logic [NSLOT-1:0] fl;
  logic [NSLOT-1:0] cond;

  //////////////////////////////////////////////////////////////////////
  // APB slave: decode, write, registered read data
  always_comb begin
    setup = psel && !penable;
    slot_sel = paddr[7:5];
    reg_idx = paddr[4:2];
    // aligned word in the slot area or a channel-wide word
    hit = (paddr[1:0] == 2'h0)
       && ((32'(slot_sel) < NSLOT) || paddr == OFF_SPAN
           || paddr == OFF_TPS || paddr == OFF_STATUS);
    wr_en = psel && penable && pwrite && hit;
    // read data loaded in the setup cycle, held otherwise
    next_prdata = prdata;
    if (setup && !pwrite) begin
      next_prdata = '0;
      // slot words
      if (32'(slot_sel) < NSLOT) begin
        case (reg_idx)
          IDX_CFG:     next_prdata = cfg[slot_sel];
          IDX_LEVEL:   next_prdata = 32'(lvl[slot_sel]);
          IDX_DEV:     next_prdata = 32'(devr[slot_sel]);
          IDX_HYST:    next_prdata = 32'(hyst[slot_sel]);
          IDX_DAMP:    next_prdata = 32'(damp[slot_sel]);
          IDX_REFLASH: next_prdata = 32'(rfl[slot_sel]);
          IDX_WINDOW:  next_prdata = 32'(win[slot_sel]);
          IDX_DIGMASK: next_prdata = 32'(dmask[slot_sel]);
          default:     next_prdata = '0;
        endcase
      end else if (paddr == OFF_SPAN) begin
        next_prdata = 32'(span);
      end else if (paddr == OFF_TPS) begin
        next_prdata = 32'(tps);
      end else if (paddr == OFF_STATUS) begin
        next_prdata = status;
      end
    end
  end

  // status word: active, flash and condition per slot
  always_comb begin
    status = '0;
    status[S_ACTIVE+:NSLOT] = slot_active;
    status[S_FLASH+:NSLOT] = slot_flash;
    status[S_COND+:NSLOT] = cond;
  end

  // no wait states
  assign pready = 1'b1;
  // unmapped or unaligned address refused in the access phase
  assign pslverr = psel && penable && !hit;

  // register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // every slot starts disabled
      for (int i = 0; i < NSLOT; i++) begin
        cfg[i] <= RST_CFG;
        lvl[i] <= '0;
        devr[i] <= '0;
        hyst[i] <= '0;
        damp[i] <= RST_TIME;
        rfl[i] <= RST_TIME;
        win[i] <= RST_TIME;
        dmask[i] <= '0;
      end
      // channel-wide defaults
      span <= VW'(RST_SPAN);
      tps <= TPS_RST;
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
      // slot words; status is read-only
      if (wr_en && 32'(slot_sel) < NSLOT) begin
        case (reg_idx)
          IDX_CFG:     cfg[slot_sel] <= pwdata;
          IDX_LEVEL:   lvl[slot_sel] <= pwdata[VW-1:0];
          IDX_DEV:     devr[slot_sel] <= pwdata[VW-1:0];
          IDX_HYST:    hyst[slot_sel] <= pwdata[7:0];
          IDX_DAMP:    damp[slot_sel] <= pwdata[16:0];
          IDX_REFLASH: rfl[slot_sel] <= pwdata[16:0];
          IDX_WINDOW:  win[slot_sel] <= pwdata[16:0];
          IDX_DIGMASK: dmask[slot_sel] <= pwdata[NDIG-1:0];
          default:     ;
        endcase
      end else if (wr_en && paddr == OFF_SPAN) begin
        span <= pwdata[VW-1:0];
      end else if (wr_en && paddr == OFF_TPS) begin
        tps <= pwdata[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // digital inputs from pins: two-flop synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_s1 <= '0;
      dig_s2 <= '0;
    end else begin
      dig_s1 <= dig_in;
      dig_s2 <= dig_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // seconds derived from sample ticks
  always_comb begin
    sec = sample_tick && (tick_cnt + 16'd1 >= tps);
    next_tick_cnt = tick_cnt;
    if (sample_tick) begin
      next_tick_cnt = sec ? 16'd0 : tick_cnt + 16'd1;
    end
  end

  // tick counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // six independent slots
  // every slot sees the same sample, tick and second
  genvar g;
  generate
    for (g = 0; g < NSLOT; g++) begin : g_slot
      logic [3:0] rsel;
      // reference index wraps onto the reference bus
      assign rsel = cfg[g][F_REFSEL+:4];
      cae_slot #(
        .VW   (VW),
        .NDIG (NDIG)
      ) u_slot (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick      (sample_tick),
        .sec       (sec),
        .value     (chan_value),
        .ref_value (ref_values[(32'(rsel) % NREF)*VW +: VW]),
        .dig       (dig_s2),
        .ack       (ack_req[g]),
        .cfg       (cfg[g]),
        .level     (lvl[g]),
        .dev       (devr[g]),
        .hyst_pct  (hyst[g]),
        .damp_s    (damp[g]),
        .reflash_s (rfl[g]),
        .window_s  (win[g]),
        .dig_mask  (dmask[g]),
        .span      (span),
        .active    (act[g]),
        .flash     (fl[g]),
        .in_alarm  (cond[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // output aggregation: relays, logging rate, chart mark
  logic [NRELAY-1:0] next_relay;
  logic              next_common;
  logic              next_lograte;
  logic              next_chart;
  logic              next_mark;
  always_comb begin
    next_relay = '0;
    next_common = 1'b0;
    next_lograte = 1'b0;
    next_chart = 1'b0;
    next_mark = 1'b0;
    // OR of every active slot's settings
    for (int i = 0; i < NSLOT; i++) begin
      if (act[i]) begin
        next_relay = next_relay | cfg[i][F_RELAY+:NRELAY];
        next_common = next_common | cfg[i][F_COMMON];
        next_lograte = next_lograte | cfg[i][F_CHGLOG];
        next_chart = next_chart | cfg[i][F_MARK];
        next_mark = next_mark | (cfg[i][F_MARK] && !slot_active[i]);
      end
    end
  end

  // output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_active <= '0;
      slot_flash <= '0;
      relay_out <= '0;
      common_relay <= 1'b0;
      log_rate_alarm <= 1'b0;
      chart_alarm <= 1'b0;
      mark_event <= 1'b0;
    end else begin
      slot_active <= act;
      slot_flash <= fl;
      relay_out <= next_relay;
      common_relay <= next_common;
      log_rate_alarm <= next_lograte;
      chart_alarm <= next_chart;
      mark_event <= next_mark;
    end
  end
endmodule : cae_top
`default_nettype wire

/* File: tb/cae_top_assertions.sv */
// concurrent checks on the alarm evaluator ports
`default_nettype none
module cae_top_assertions
  import cae_pkg::*;
#(
  parameter int NRELAY = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              sample_tick,
  input wire logic [NSLOT-1:0]  ack_req,
  input wire logic [NSLOT-1:0]  slot_active,
  input wire logic [NSLOT-1:0]  slot_flash,
  input wire logic [NRELAY-1:0] relay_out,
  input wire logic              common_relay,
  input wire logic              log_rate_alarm,
  input wire logic              chart_alarm,
  input wire logic              mark_event
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // acknowledge with no sample tick close enough to set again
  sequence s_ack_clean;
    (ack_req != '0) && !sample_tick && !$past(sample_tick) && !$past(sample_tick, 2);
  endsequence
  // some slot output newly raised
  sequence s_new_slot;
    (slot_active & ~$past(slot_active)) != '0;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_no_wait_state: assert property (pready)
    else $error("pready low");
  a_err_decode: assert property (
    pslverr == (psel && penable && (paddr[1:0] != 2'h0 || paddr > OFF_STATUS)))
    else $error("pslverr decode wrong");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_rise_on_tick:
    assert property (s_new_slot |-> $past(sample_tick, 2))
    else $error("slot raised without a tick");
  a_mark_on_entry:
    assert property (mark_event |-> chart_alarm && (slot_active & ~$past(slot_active)) != '0)
    else $error("mark pulse without entry");
  a_idle_outputs:
    assert property (slot_active == '0 |->
      relay_out == '0 && !common_relay && !log_rate_alarm && !chart_alarm)
    else $error("outputs high with no active slot");
  a_flash_in_active:
    assert property ((slot_flash & ~slot_active) == '0)
    else $error("flash on an inactive slot");
  a_ack_clears_flash:
    assert property (s_ack_clean |-> ##2 (slot_flash & $past(ack_req, 2)) == '0)
    else $error("flash kept after acknowledge");
endmodule : cae_top_assertions
bind cae_top cae_top_assertions #(.NRELAY(NRELAY)) i_cae_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sample_tick(sample_tick), .ack_req(ack_req),
  .slot_active(slot_active), .slot_flash(slot_flash), .relay_out(relay_out),
  .common_relay(common_relay), .log_rate_alarm(log_rate_alarm),
  .chart_alarm(chart_alarm), .mark_event(mark_event)
);
`default_nettype wire

/* File: tb/tb_cae_top.sv */
// self-checking bench for the channel alarm evaluator
`default_nettype none
module tb_cae_top
  import cae_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic               sample_tick = 1'b0;
  logic signed [15:0] chan_value = 16'h0000;
  logic [127:0]       ref_values = 128'h0;
  logic [7:0]         dig_in = 8'h00;
  logic [5:0]         ack_req = 6'h00;
  logic [31:0]        prdata, rv;
  logic [5:0]         slot_active, slot_flash;
  logic [7:0]         relay_out;
  logic               pready, pslverr, serr, common_relay, log_rate_alarm;
  logic               chart_alarm, mark_event;
  logic               smark = 1'b0;
  logic               sact = 1'b0;
  int                 errors = 0;
  int                 compares = 0;

  cae_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_tick(sample_tick), .chan_value(chan_value), .ref_values(ref_values),
    .dig_in(dig_in), .ack_req(ack_req), .slot_active(slot_active), .slot_flash(slot_flash),
    .relay_out(relay_out), .common_relay(common_relay), .log_rate_alarm(log_rate_alarm),
    .chart_alarm(chart_alarm), .mark_event(mark_event)
  );
  ////////////////////////////////////////////////////////////////////////////
  // clock and sticky records of pulses
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (mark_event === 1'b1) smark <= 1'b1;
    if (slot_active[5] === 1'b1) sact <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one transfer; data and error taken at the completing edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cw(input int s, input logic [2:0] i, input logic [31:0] d);
    apb(1'b1, 8'(s * 32 + i * 4), d);
  endtask : cw
  // hold a value over n ticks; outputs settled on return
  task automatic tk(input logic signed [15:0] v, input int n);
    chan_value <= v;
    repeat (n) begin
      sample_tick <= 1'b1;
      @(posedge pclk);
      sample_tick <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask : tk
  task automatic ack(input logic [5:0] m);
    ack_req <= m;
    @(posedge pclk);
    ack_req <= 6'h00;
    repeat (3) @(posedge pclk);
  endtask : ack
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0);
    chk(rv, RST_CFG);
    apb(1'b0, OFF_SPAN, 32'h0);
    chk(rv, 32'h0000_0064);
    apb(1'b0, 8'h30, 32'h0);
    chk(rv, 32'h0000_0001);
    apb(1'b0, OFF_TPS, 32'h0);
    chk(rv, 32'h0000_000a);
    apb(1'b0, 8'hcc, 32'h0);
    chk(serr, 1'b1);
    chk(rv, 32'h0);
    apb(1'b1, OFF_TPS, 32'h0000_0001);
    $display("test reset done");
  endtask : t_reset
  task automatic t_high();
    cw(0, IDX_LEVEL, 32'h0000_0064);
    cw(0, IDX_CFG, 32'h0005_08c1);
    tk(16'h0064, 1);
    chk(slot_active, 6'h00);
    smark <= 1'b0;
    tk(16'h0065, 1);
    chk(slot_active, 6'h01);
    chk({common_relay, relay_out}, 9'h105);
    chk({log_rate_alarm, chart_alarm, smark}, 3'h7);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rv, 32'h0001_0101);
    tk(16'h0032, 1);
    chk({log_rate_alarm, chart_alarm, common_relay, relay_out}, 11'h000);
    cw(0, IDX_HYST, 32'h0000_000a);
    cw(0, IDX_CFG, 32'h0000_0101);
    tk(16'h0065, 1);
    tk(16'h005b, 1);
    chk(slot_active[0], 1'b1);
    tk(16'h005a, 1);
    chk(slot_active[0], 1'b0);
    cw(0, IDX_CFG, 32'h0);
    $display("test high done");
  endtask : t_high
  task automatic t_latch();
    cw(1, IDX_REFLASH, 32'h0000_0002);
    cw(1, IDX_CFG, 32'h0000_0425);
    tk(16'hffff, 1);
    chk({slot_active[1], slot_flash[1]}, 2'h3);
    tk(16'h0000, 1);
    chk({slot_active[1], slot_flash[1]}, 2'h3);
    ack(6'h02);
    chk({slot_active[1], slot_flash[1]}, 2'h0);
    tk(16'hffff, 1);
    ack(6'h02);
    chk({slot_active[1], slot_flash[1]}, 2'h2);
    tk(16'hffff, 1);
    chk(slot_flash[1], 1'b0);
    tk(16'hffff, 3);
    chk(slot_flash[1], 1'b1);
    ack(6'h02);
    tk(16'h0005, 1);
    chk(slot_active[1], 1'b0);
    cw(1, IDX_CFG, 32'h0);
    $display("test latch done");
  endtask : t_latch
  task automatic t_damp();
    cw(2, IDX_DAMP, 32'h0000_fd20);
    apb(1'b0, 8'h50, 32'h0);
    chk(rv, 32'h0000_fd20);
    cw(2, IDX_DAMP, 32'h0000_0003);
    cw(2, IDX_CFG, 32'h0000_0201);
    tk(16'h0001, 2);
    chk(slot_active[2], 1'b0);
    tk(16'hfffb, 1);
    tk(16'h0001, 2);
    chk(slot_active[2], 1'b0);
    tk(16'h0001, 2);
    chk(slot_active[2], 1'b1);
    tk(16'hfffb, 1);
    chk(slot_active[2], 1'b0);
    cw(2, IDX_CFG, 32'h0);
    $display("test damp done");
  endtask : t_damp
  task automatic t_dig_dev();
    cw(3, IDX_DIGMASK, 32'h0000_0010);
    cw(3, IDX_CFG, 32'h0000_0002);
    tk(16'h0001, 1);
    chk(slot_active[3], 1'b0);
    dig_in <= 8'h10;
    repeat (3) @(posedge pclk);
    tk(16'h0001, 1);
    chk(slot_active[3], 1'b1);
    cw(3, IDX_CFG, 32'h0);
    tk(16'h0001, 1);
    chk(slot_active[3], 1'b0);
    ref_values[63:48] <= 16'h0032;
    cw(4, IDX_DEV, 32'h0000_000a);
    cw(4, IDX_CFG, 32'h0000_3009);
    tk(16'h003c, 1);
    chk(slot_active[4], 1'b0);
    tk(16'h003d, 1);
    chk(slot_active[4], 1'b1);
    tk(16'h0027, 1);
    chk(slot_active[4], 1'b1);
    tk(16'h002d, 1);
    chk(slot_active[4], 1'b0);
    cw(4, IDX_CFG, 32'h0);
    $display("test gate and deviation done");
  endtask : t_dig_dev
  task automatic t_rate();
    logic signed [15:0] b, m, e;
    cw(5, IDX_DEV, 32'h0000_000a);
    cw(5, IDX_WINDOW, 32'h0000_0002);
    for (int k = 0; k < 2; k++) begin
      b = (k == 0) ? 16'h0000 : 16'h0014;
      m = (k == 0) ? 16'h0005 : 16'h000f;
      e = (k == 0) ? 16'h0014 : 16'h0000;
      cw(5, IDX_CFG, (k == 0) ? 32'h0000_000d : 32'h0000_0011);
      tk(b, 4);
      tk(m, 3);
      chk(slot_active[5], 1'b0);
      sact <= 1'b0;
      tk(e, 2);
      chk(sact, 1'b1);
    end
    cw(5, IDX_CFG, 32'h0);
    $display("test rate done");
  endtask : t_rate
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  // reset, scenarios, verdict
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_high();
    t_latch();
    t_damp();
    t_dig_dev();
    t_rate();
    give_verdict();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict();
  end
endmodule : tb_cae_top
`default_nettype wire
